// ### src/adcc_params.svh
// Offsets, field positions, reset values and cycle counts of the converter control block.
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// Register indexes; the byte address on APB is four times the index.
`define ADCC_IDX_RES_LO   8'h78
`define ADCC_IDX_RES_HI   8'h79
`define ADCC_IDX_CSR      8'h7A
`define ADCC_IDX_TRG      8'h7B
`define ADCC_IDX_MUX      8'h7C

// Field positions in converter_control_status.
`define ADCC_CSR_EN       7
`define ADCC_CSR_START    6
`define ADCC_CSR_AUTO     5
`define ADCC_CSR_FLAG     4
`define ADCC_CSR_IE       3

// Field positions in input_reference_select.
`define ADCC_MUX_LEFT     5

`define ADCC_RST_BYTE     8'h00
`define ADCC_RST_RESULT   10'h000

// Converter clock cycles per conversion.
`define ADCC_FIRST_CYC    5'd25
`define ADCC_NORMAL_CYC   5'd13

`define ADCC_TRG_FREERUN  3'h0

// Channel codes of differential pairs.
`define ADCC_DIFF_LO      5'h08
`define ADCC_DIFF_HI      5'h1D

`endif

// ### src/adcc_pkg.sv
// Types shared by the converter control block.
`default_nettype none

package adcc_pkg;

    typedef enum logic {ST_IDLE, ST_CONV} adcc_state_e;

    typedef logic [9:0] adcc_result_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } adcc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } adcc_apb_rsp_s;

    typedef struct packed {
        logic       power;
        logic [1:0] refSel;
        logic [4:0] chanSel;
        logic       convBusy;
        logic       initConv;
        logic       sampleTick;
    } adcc_front_s;

endpackage

`default_nettype wire

// ### src/adcc_prescaler.sv
// Converter clock enable divider.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"

module adcc_prescaler
(
    input  wire logic       mclk,    // System clock.
    input  wire logic       rst_n,   // Asynchronous reset, active low.
    input  wire logic       run,     // Converter enabled.
    input  wire logic [2:0] divSel,  // Division select code.
    output logic            tick     // One-cycle converter clock enable.
);

    logic [6:0] cntFf;
    logic       tickFf;

    function automatic logic [6:0] div_last(input logic [2:0] code);
        case (code)
            3'h0, 3'h1: div_last = 7'd1;
            3'h2:       div_last = 7'd3;
            3'h3:       div_last = 7'd7;
            3'h4:       div_last = 7'd15;
            3'h5:       div_last = 7'd31;
            3'h6:       div_last = 7'd63;
            default:    div_last = 7'd127;
        endcase
    endfunction

    // Holding the counter at zero while disabled saves power and gives each enable a clean phase.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cntFf <= 7'd0;
        else if (!run)
            cntFf <= 7'd0;
        else if (cntFf >= div_last(divSel))
            cntFf <= 7'd0;
        else
            cntFf <= cntFf + 7'd1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tickFf <= 1'b0;
        else
            tickFf <= run && (cntFf >= div_last(divSel));
    end

    assign tick = tickFf;

    tick_stop_a: assert property (
        @(posedge mclk) disable iff (!rst_n) !run |=> !tick)
        else $error("converter clock ticks while disabled");

    div_two_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tick && run && divSel == 3'h0 ##1 (run && divSel == 3'h0) [*2] |-> tick)
        else $error("divide by two period wrong");

endmodule

`default_nettype wire

// ### src/adcc_ctrl.sv
// Register file and conversion sequencer of the successive-approximation converter.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"

module adcc_ctrl
(
    input  wire logic                  mclk,        // System clock, 20 MHz.
    input  wire logic                  rst_n,       // Asynchronous reset, active low.
    input  wire adcc_pkg::adcc_apb_req_s apbReq,    // APB request.
    output adcc_pkg::adcc_apb_rsp_s    apbRsp,      // APB response.
    input  wire logic [7:1]            trigIn,      // Auto-trigger source levels.
    input  wire logic                  globalIrqEn, // Processor global interrupt enable.
    input  wire logic                  irqAck,      // Interrupt vector executed.
    output logic                       irqReq,      // Conversion complete request.
    input  wire adcc_pkg::adcc_result_t coreResult, // Code from the converter core.
    output adcc_pkg::adcc_front_s      front        // Controls to the analog front end.
);
    import adcc_pkg::*;

    // ******************************************************************
    // Bus decode
    // ******************************************************************
    logic       accessPh;
    logic       setupPh;
    logic       wrAcc;
    logic       rdAcc;
    logic [7:0] regIdx;
    logic       aligned;

    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx >= `ADCC_IDX_RES_LO) && (idx <= `ADCC_IDX_MUX);
    endfunction

    function automatic logic is_diff(input logic [4:0] code);
        is_diff = (code >= `ADCC_DIFF_LO) && (code <= `ADCC_DIFF_HI);
    endfunction

    assign setupPh  = apbReq.psel && !apbReq.penable;
    assign accessPh = apbReq.psel && apbReq.penable;
    assign regIdx   = apbReq.paddr[9:2];
    assign aligned  = (apbReq.paddr[1:0] == 2'b00) && (apbReq.paddr[11:10] == 2'b00) && idx_mapped(regIdx);
    assign wrAcc    = accessPh && apbReq.pwrite && aligned;
    assign rdAcc    = accessPh && !apbReq.pwrite && aligned;

    logic csrWr;
    logic muxWr;
    logic trgWr;

    assign csrWr = wrAcc && (regIdx == `ADCC_IDX_CSR);
    assign muxWr = wrAcc && (regIdx == `ADCC_IDX_MUX);
    assign trgWr = wrAcc && (regIdx == `ADCC_IDX_TRG);

    // ******************************************************************
    // Control registers
    // ******************************************************************
    logic       enFf;
    logic       autoFf;
    logic       ieFf;
    logic [2:0] divFf;
    logic [1:0] refFf;
    logic       leftFf;
    logic [4:0] chanFf;
    logic [2:0] trgSelFf;
    logic       nxt_en;

    assign nxt_en = csrWr ? apbReq.pwdata[`ADCC_CSR_EN] : enFf;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enFf   <= 1'b0;
            autoFf <= 1'b0;
            ieFf   <= 1'b0;
            divFf  <= 3'h0;
        end
        else if (csrWr)
        begin
            enFf   <= nxt_en;
            autoFf <= apbReq.pwdata[`ADCC_CSR_AUTO];
            ieFf   <= apbReq.pwdata[`ADCC_CSR_IE];
            divFf  <= apbReq.pwdata[2:0];
        end
    end

    // The live copy always reads back what was written; the front end sees the latched copy while busy.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            refFf  <= 2'h0;
            leftFf <= 1'b0;
            chanFf <= 5'h00;
        end
        else if (muxWr)
        begin
            refFf  <= apbReq.pwdata[7:6];
            leftFf <= apbReq.pwdata[`ADCC_MUX_LEFT];
            chanFf <= apbReq.pwdata[4:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            trgSelFf <= 3'h0;
        else if (trgWr)
            trgSelFf <= apbReq.pwdata[2:0];
    end

    // ******************************************************************
    // Converter clock
    // ******************************************************************
    logic adcTick;

    adcc_prescaler u_prescaler
    (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .run    (enFf),
        .divSel (divFf),
        .tick   (adcTick)
    );

    // ******************************************************************
    // Conversion sequencer
    // ******************************************************************
    adcc_state_e stateFf;
    logic [4:0]  cycCntFf;
    logic        firstFf;
    logic        firstPendFf;
    logic [1:0]  actRefFf;
    logic [4:0]  actChanFf;
    logic        trigPrevFf;
    logic        trigSig;
    logic        trigEdge;
    logic        enRise;
    logic        startWr;
    logic        convEnd;
    logic        freeRestart;
    logic        startReq;
    logic [4:0]  cycLast;

    assign enRise  = nxt_en && !enFf;
    assign startWr = csrWr && apbReq.pwdata[`ADCC_CSR_START] && nxt_en;
    // Code zero selects a constant low so switching to it never makes an edge.
    assign trigSig = (trgSelFf == `ADCC_TRG_FREERUN) ? 1'b0 : trigIn[trgSelFf];
    assign trigEdge = autoFf && enFf && trigSig && !trigPrevFf;
    assign cycLast  = firstFf ? (`ADCC_FIRST_CYC - 5'd1) : (`ADCC_NORMAL_CYC - 5'd1);
    assign convEnd  = (stateFf == ST_CONV) && adcTick && (cycCntFf == cycLast);
    assign freeRestart = convEnd && autoFf && (trgSelFf == `ADCC_TRG_FREERUN) && nxt_en;
    assign startReq = nxt_en && (((stateFf == ST_IDLE) && (startWr || trigEdge)) || freeRestart);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            trigPrevFf <= 1'b0;
        else
            trigPrevFf <= trigSig;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            stateFf <= ST_IDLE;
        else
        begin
            case (stateFf)
                ST_IDLE:
                begin
                    if (startReq)
                        stateFf <= ST_CONV;
                end
                ST_CONV:
                begin
                    if (!nxt_en)
                        stateFf <= ST_IDLE;
                    else if (convEnd && !freeRestart)
                        stateFf <= ST_IDLE;
                end
                default:
                    stateFf <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cycCntFf <= 5'd0;
        else if (startReq)
            cycCntFf <= 5'd0;
        else if ((stateFf == ST_CONV) && adcTick)
            cycCntFf <= cycCntFf + 5'd1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            firstPendFf <= 1'b0;
        else if (!nxt_en || startReq)
            firstPendFf <= 1'b0;
        else if (enRise)
            firstPendFf <= 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            firstFf   <= 1'b0;
            actRefFf  <= 2'h0;
            actChanFf <= 5'h00;
        end
        else if (startReq)
        begin
            firstFf   <= firstPendFf || enRise;
            actRefFf  <= muxWr ? apbReq.pwdata[7:6] : refFf;
            actChanFf <= muxWr ? apbReq.pwdata[4:0] : chanFf;
        end
    end

    // ******************************************************************
    // Result, lock and completion flag
    // ******************************************************************
    adcc_result_t resFf;
    logic         lockFf;
    logic         flagFf;
    logic         flagClr;
    logic         resUpd;

    assign resUpd  = convEnd && !lockFf;
    assign flagClr = irqAck || (csrWr && apbReq.pwdata[`ADCC_CSR_FLAG]);

    // The core gives offset binary for pairs; flipping the top bit yields two's complement.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            resFf <= `ADCC_RST_RESULT;
        else if (resUpd)
            resFf <= is_diff(actChanFf) ? {~coreResult[9], coreResult[8:0]} : coreResult;
    end

    // A low byte read freezes the pair so the two halves belong to one conversion, except when one ends in the setup or access cycle of that read.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            lockFf <= 1'b0;
        else if (rdAcc && (regIdx == `ADCC_IDX_RES_LO))
            lockFf <= 1'b1;
        else if (rdAcc && (regIdx == `ADCC_IDX_RES_HI))
            lockFf <= 1'b0;
    end

    // A completion in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            flagFf <= 1'b0;
        else if (resUpd)
            flagFf <= 1'b1;
        else if (flagClr)
            flagFf <= 1'b0;
    end

    assign irqReq = flagFf && ieFf && globalIrqEn;

    // ******************************************************************
    // Read data and front end
    // ******************************************************************
    logic [7:0] rdByte;
    logic [31:0] prdataFf;

    always_comb
    begin
        rdByte = 8'h00;
        case (regIdx)
            `ADCC_IDX_RES_LO: rdByte = leftFf ? {resFf[1:0], 6'h00} : resFf[7:0];
            `ADCC_IDX_RES_HI: rdByte = leftFf ? resFf[9:2] : {6'h00, resFf[9:8]};
            `ADCC_IDX_CSR:    rdByte = {enFf, (stateFf == ST_CONV), autoFf, flagFf, ieFf, divFf};
            `ADCC_IDX_TRG:    rdByte = {5'h00, trgSelFf};
            `ADCC_IDX_MUX:    rdByte = {refFf, leftFf, chanFf};
            default:          rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            prdataFf <= 32'h0000_0000;
        else if (setupPh)
            prdataFf <= {24'h00_0000, rdByte};
    end

    assign apbRsp.prdata  = prdataFf;
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.pslverr = accessPh && !aligned;

    // The core decodes reference and channel codes into switch settings.
    assign front.power      = enFf;
    assign front.refSel     = (stateFf == ST_CONV) ? actRefFf : refFf;
    assign front.chanSel    = (stateFf == ST_CONV) ? actChanFf : chanFf;
    assign front.convBusy   = (stateFf == ST_CONV);
    assign front.initConv   = (stateFf == ST_CONV) && firstFf;
    assign front.sampleTick = (stateFf == ST_CONV) && adcTick;

    // ******************************************************************
    // Assertions
    // ******************************************************************
    logic [4:0] tickSeen;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tickSeen <= 5'd0;
        else if (startReq)
            tickSeen <= 5'd0;
        else if ((stateFf == ST_CONV) && adcTick)
            tickSeen <= tickSeen + 5'd1;
    end

    ref_hold_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        front.convBusy && $past(front.convBusy) && !$past(startReq) |-> front.refSel == $past(front.refSel))
        else $error("reference changed mid conversion");

    chan_hold_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        front.convBusy && $past(front.convBusy) && !$past(startReq) |-> front.chanSel == $past(front.chanSel))
        else $error("channel changed mid conversion");

    conv_len_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        convEnd |-> (tickSeen + 5'd1) == (firstFf ? 5'd25 : 5'd13))
        else $error("conversion length wrong");

    flag_set_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        resUpd |=> flagFf && resFf == $past(is_diff(actChanFf) ? {~coreResult[9], coreResult[8:0]} : coreResult))
        else $error("flag or result not updated at completion");

    flag_clear_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        flagFf && irqAck && !resUpd |=> !flagFf)
        else $error("acknowledge did not clear flag");

    irq_gate_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        irqReq |-> flagFf && ieFf && globalIrqEn)
        else $error("interrupt without all enables");

    abort_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !enFf |-> !front.convBusy)
        else $error("conversion runs while disabled");

    busy_read_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        setupPh && regIdx == `ADCC_IDX_CSR |=> prdataFf[6] == $past(front.convBusy))
        else $error("start bit does not mirror busy");

    lock_hold_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        lockFf |=> resFf == $past(resFf))
        else $error("result changed while locked");

    first_conv_c: cover property (@(posedge mclk) disable iff (!rst_n) convEnd && firstFf);
    locked_end_c: cover property (@(posedge mclk) disable iff (!rst_n) convEnd && lockFf);
    auto_trig_c:  cover property (@(posedge mclk) disable iff (!rst_n) trigEdge && startReq);
    free_run_c:   cover property (@(posedge mclk) disable iff (!rst_n) freeRestart);

endmodule

`default_nettype wire

// ### verif/adcc_core_model.sv
// Behavioural model of the converter core that answers the control block.
`timescale 1ns/100ps
`default_nettype none

module adcc_core_model
(
    input  wire logic                  mclk,       // System clock.
    input  wire logic                  rst_n,      // Asynchronous reset, active low.
    input  wire adcc_pkg::adcc_front_s front,      // Controls from the block.
    output var adcc_pkg::adcc_result_t coreResult  // Code back to the block.
);
    import adcc_pkg::*;

    adcc_result_t lastCode_ff;

    // Outside a conversion the code flips every cycle, so a sample taken at the wrong moment cannot match.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            lastCode_ff <= 10'h000;
        else
            lastCode_ff <= ~coreResult;
    end

    // The code is built from the selections the block presents, so a stale selection shows in the result.
    assign coreResult = front.convBusy ? {front.chanSel, front.refSel, 3'h5} : lastCode_ff;
endmodule
`default_nettype wire

// ### verif/adc_control_registers_test.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"

module adc_control_registers_test;
    import adcc_pkg::*;

    typedef struct {logic [7:0] mux; logic [2:0] div; int ticks;} adcc_row_s;

    logic          mclk;
    logic          rst_n;
    logic          globalIrqEn;
    logic          irqAck;
    logic          irqReq;
    logic [7:1]    trigIn;
    adcc_apb_req_s req;
    adcc_apb_rsp_s rsp;
    adcc_result_t  coreResult;
    adcc_front_s   front;
    int            mismatches;
    int            checks;
    int            busyCnt;
    int            tickCnt;
    int            initCnt;
    logic [31:0]   rd;
    logic          err;
    logic [9:0]    held;
    // Differential rows use only the 2.56V reference and nothing drives the external reference pin.
    adcc_row_s     rows[8] = '{'{8'h00, 3'h0, 25}, '{8'h47, 3'h1, 13}, '{8'hE8, 3'h2, 13},
                               '{8'hFD, 3'h3, 13}, '{8'hDE, 3'h4, 13}, '{8'h3F, 3'h5, 13},
                               '{8'hD0, 3'h6, 13}, '{8'hEF, 3'h7, 13}};

    adcc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp), .trigIn(trigIn),
                   .globalIrqEn(globalIrqEn), .irqAck(irqAck), .irqReq(irqReq),
                   .coreResult(coreResult), .front(front));
    adcc_core_model core (.mclk(mclk), .rst_n(rst_n), .front(front), .coreResult(coreResult));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Busy cycles, converter clock ticks and initialising cycles of the running conversion.
    always @(posedge mclk)
    begin
        if (front.convBusy === 1'b1)
            busyCnt <= busyCnt + 1;
        if (front.sampleTick === 1'b1)
            tickCnt <= tickCnt + 1;
        if (front.initConv === 1'b1)
            initCnt <= initCnt + 1;
    end

    // ****************************************
    // Bus cycles and comparisons
    // ****************************************
    // The access phase lasts until pready is seen high; only the watchdog ends a wait that never finishes.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge mclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '{1'b0, 1'b0, 1'b0, a, {24'h0, d}};
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, d);
    endtask

    task automatic rdr(input logic [7:0] i);
        apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkRange(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi)
        begin
            mismatches++;
            $display("MISMATCH at %0t: busy cycles %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    function automatic logic [9:0] expRes(input logic [7:0] mux);
        logic [9:0] r;
        r = {mux[4:0], mux[7:6], 3'h5};
        if (mux[4:0] >= `ADCC_DIFF_LO && mux[4:0] <= `ADCC_DIFF_HI)
            r[9] = ~r[9];
        return r;
    endfunction

    task automatic checkRes(input logic [9:0] r, input logic left);
        logic [15:0] v;
        v = left ? {r, 6'h00} : {6'h00, r};
        rdr(`ADCC_IDX_RES_LO);
        chk(rd, {24'h0, v[7:0]});
        rdr(`ADCC_IDX_RES_HI);
        chk(rd, {24'h0, v[15:8]});
    endtask

    task automatic waitDone;
        int n = 0;
        while (front.convBusy !== 1'b1 && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400)
        begin
            mismatches++;
            $display("MISMATCH at %0t: conversion never started", $time);
        end
        while (front.convBusy === 1'b1 && n < 5000)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 5000)
        begin
            mismatches++;
            $display("MISMATCH at %0t: conversion never ended", $time);
        end
    endtask

    // Control writes carry the whole intended byte; nothing is read back and rewritten.
    task automatic conv(input logic [7:0] csr);
        busyCnt = 0;
        tickCnt = 0;
        initCnt = 0;
        wr(`ADCC_IDX_CSR, csr);
        waitDone();
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The longest row runs 13 ticks of 128 cycles; the whole run stays far below this span.
    initial
    begin
        #(20000 * 50);
        mismatches++;
        end_of_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        trigIn = '0;
        globalIrqEn = 1'b0;
        irqAck = 1'b0;
        mismatches = 0;
        checks = 0;
        busyCnt = 0;
        tickCnt = 0;
        initCnt = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 8'h78; i <= 8'h7C; i++)
        begin
            rdr(i[7:0]);
            chk(rd, 32'h0);
        end
        rdr(8'h7D);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h1E9, 8'h00);
        chk({31'h0, err}, 32'h1);
        foreach (rows[k])
        begin
            int dv;
            dv = (rows[k].div < 3'h2) ? 2 : (1 << rows[k].div);
            wr(`ADCC_IDX_MUX, rows[k].mux);
            conv(8'hC0 | rows[k].div);
            chkRange(busyCnt, dv * (rows[k].ticks - 1), dv * rows[k].ticks + 2);
            chk(tickCnt, rows[k].ticks);
            chk({31'h0, initCnt != 0}, {31'h0, rows[k].ticks == 25});
            checkRes(expRes(rows[k].mux), rows[k].mux[5]);
            rdr(`ADCC_IDX_CSR);
            chk(rd, {24'h0, 8'h90 | rows[k].div});
            wr(`ADCC_IDX_CSR, 8'h90 | rows[k].div);
            rdr(`ADCC_IDX_CSR);
            chk(rd, {24'h0, 8'h80 | rows[k].div});
        end
        wr(`ADCC_IDX_MUX, 8'h00);
        busyCnt = 0;
        tickCnt = 0;
        wr(`ADCC_IDX_CSR, 8'hC0);
        wr(`ADCC_IDX_MUX, 8'hC5);
        chk({25'h0, front.refSel, front.chanSel}, 32'h0);
        rdr(`ADCC_IDX_CSR);
        chk({31'h0, rd[6]}, 32'h1);
        wr(`ADCC_IDX_CSR, 8'h80);
        chk({31'h0, front.convBusy}, 32'h1);
        waitDone();
        chkRange(busyCnt, 24, 28);
        chk(tickCnt, 13);
        held = expRes(8'h00);
        checkRes(held, 1'b0);
        chk({25'h0, front.refSel, front.chanSel}, 32'h65);
        wr(`ADCC_IDX_MUX, 8'hE5);
        checkRes(held, 1'b1);
        wr(`ADCC_IDX_CSR, 8'h90);
        // A low-byte read locks the result, so the next completion is dropped.
        rdr(`ADCC_IDX_RES_LO);
        conv(8'hC0);
        rdr(`ADCC_IDX_CSR);
        chk(rd, 32'h80);
        rdr(`ADCC_IDX_RES_HI);
        chk(rd, {24'h0, held[9:2]});
        conv(8'hC8);
        checkRes(expRes(8'hE5), 1'b1);
        globalIrqEn <= 1'b1;
        @(posedge mclk);
        chk({31'h0, irqReq}, 32'h1);
        globalIrqEn <= 1'b0;
        @(posedge mclk);
        chk({31'h0, irqReq}, 32'h0);
        wr(`ADCC_IDX_CSR, 8'h88);
        globalIrqEn <= 1'b1;
        @(posedge mclk);
        chk({31'h0, irqReq}, 32'h1);
        irqAck <= 1'b1;
        @(posedge mclk);
        irqAck <= 1'b0;
        @(posedge mclk);
        chk({31'h0, irqReq}, 32'h0);
        wr(`ADCC_IDX_CSR, 8'hC0);
        repeat (4) @(posedge mclk);
        wr(`ADCC_IDX_CSR, 8'h00);
        repeat (2) @(posedge mclk);
        chk({30'h0, front.convBusy, front.power}, 32'h0);
        rdr(`ADCC_IDX_CSR);
        chk(rd, 32'h0);
        conv(8'hC0);
        chkRange(busyCnt, 48, 52);
        chk(tickCnt, 25);
        chk({31'h0, initCnt != 0}, 32'h1);
        for (int s = 1; s < 8; s++)
        begin
            wr(`ADCC_IDX_TRG, s[7:0]);
            wr(`ADCC_IDX_CSR, 8'hB0);
            busyCnt = 0;
            trigIn[s] <= 1'b1;
            waitDone();
            chkRange(busyCnt, 24, 28);
            trigIn[s] <= 1'b0;
        end
        busyCnt = 0;
        wr(`ADCC_IDX_TRG, 8'h00);
        repeat (20) @(posedge mclk);
        chkRange(busyCnt, 0, 0);
        busyCnt = 0;
        wr(`ADCC_IDX_CSR, 8'hF0);
        repeat (70) @(posedge mclk);
        chkRange(busyCnt, 60, 70);
        rdr(`ADCC_IDX_CSR);
        chk({24'h0, rd[7:0] & 8'h50}, 32'h50);
        // A second reset in mid-conversion must bring every register back.
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        chk({30'h0, front.convBusy, irqReq}, 32'h0);
        for (int i = 8'h78; i <= 8'h7C; i++)
        begin
            rdr(i[7:0]);
            chk(rd, 32'h0);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
